// ==== hw/srr_errq.sv ====
// Error queue of fixed-width text entries, oldest entry leaves first.
// Assumes push and pop are single-cycle strobes from the command decoder.
`timescale 1ns/10ps
module srr_errq
	import srr_pkg::*;
#(
	parameter int DEPTH = SRR_ERRQ_DEPTH,
	parameter int WIDTH = SRR_ERR_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	// Read side
	input wire logic pop,
	output logic [WIDTH-1:0] head_data,
	output logic not_empty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire do_pop = pop && (cnt_reg != '0);
	wire do_push = push && (cnt_reg != (AW+1)'(DEPTH));
	wire [AW-1:0] wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
	wire [AW-1:0] rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;

	// A push into a full queue is dropped, so older entries are never overwritten.
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_push) begin
				wr_reg <= wr_next;
			end
			if (do_pop) begin
				rd_reg <= rd_next;
			end
			cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	assign head_data = mem[rd_reg];
	assign not_empty = (cnt_reg != '0);
	assign full = (cnt_reg == (AW+1)'(DEPTH));

	AST_ERRQ_BOUND: assert property (@(posedge clk) disable iff (rst)
		cnt_reg <= (AW+1)'(DEPTH)) else $error("Error queue count above depth.");
	AST_ERRQ_FIFO: assert property (@(posedge clk) disable iff (rst)
		do_pop && !do_push |=> rd_reg == $past(rd_next) && cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("Error queue pop did not advance in order.");
endmodule : srr_errq

// ==== hw/srr_pkg.sv ====
// Shared constants for the status reporting register bank.
// Assumes a single system clock domain and a command decoder outside the bank.
package srr_pkg;
	// ****************************************************************
	// Register widths and bit positions
	// ****************************************************************
	localparam int SRR_QUES_W = 16;
	localparam int SRR_STD_W = 8;
	localparam int SRR_STB_W = 8;
	localparam int SRR_OPC_BIT = 0;
	localparam int SRR_EAV_BIT = 2;
	localparam int SRR_QSUM_BIT = 3;
	localparam int SRR_ESUM_BIT = 5;
	localparam int SRR_RQS_BIT = 6;
	// ****************************************************************
	// Error queue shape
	// ****************************************************************
	localparam int SRR_ERRQ_DEPTH = 20;
	localparam int SRR_ERR_CHARS = 80;
	localparam int SRR_ERR_W = SRR_ERR_CHARS * 8;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [SRR_QUES_W-1:0] SRR_QUES_RST = 16'h0000;
	localparam logic [SRR_STD_W-1:0] SRR_STD_RST = 8'h00;
	localparam logic [SRR_STB_W-1:0] SRR_STB_RST = 8'h00;
	localparam logic SRR_PSC_RST = 1'b1;
	// ****************************************************************
	// Query selector codes
	// ****************************************************************
	typedef enum logic [2:0] {
		SRR_Q_QUES_EN, SRR_Q_QUES_EV, SRR_Q_STD_EN, SRR_Q_STD_EV,
		SRR_Q_STB_EN, SRR_Q_STB, SRR_Q_PSC, SRR_Q_OPC
	} srr_query_e;
endpackage : srr_pkg

// ==== hw/srr_top.sv ====
// Status reporting register bank: error queue, questionable and standard events, status byte.
// Assumes a command decoder drives one-cycle command strobes and reads the answer on the next cycle.
// Contract
// - Error queue holds 20 entries, answered oldest first.
// - Each error entry holds up to 80 characters.
// - Questionable enable mask selects bits feeding the status byte summary.
// - Any enable mask query returns its binary-weighted value.
// - Questionable event query returns the binary-weighted value of set bits.
// - Status preset clears the questionable enable mask.
// - Clear status zeroes status summary and every event register.
// - Standard event enable mask selects bits summarised into the status byte.
// - Standard event query returns the binary-weighted value of set bits.
// - Operation complete sets standard event bit 0 after it executes.
// - Operation complete query answers 1 once executed.
// - Power-on clear at 1 clears both enable masks at power-up.
// - Power-on clear at 0 keeps both enable masks across power-up.
// - Power-on clear query returns the last programmed 0 or 1.
// - Service request mask selects status bits; query returns its value.
// - Status byte query matches serial poll but keeps request-service bit.
// - Reset to power-on configuration leaves the error queue intact.
`timescale 1ns/10ps
module srr_top
	import srr_pkg::*;
#(
	parameter int QUES_W = SRR_QUES_W,
	parameter int ERR_W = SRR_ERR_W,
	parameter int ERRQ_DEPTH = SRR_ERRQ_DEPTH
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Power cycle and configuration reset
	input wire logic POWER_ON,
	input wire logic CFG_RESET,
	// Event conditions, one-cycle pulses
	input wire logic [QUES_W-1:0] QUES_COND,
	input wire logic [SRR_STD_W-1:0] STD_COND,
	input wire logic [SRR_STB_W-1:0] STB_COND,
	// Mask and setting writes
	input wire logic QUES_EN_WR,
	input wire logic STD_EN_WR,
	input wire logic STB_EN_WR,
	input wire logic PSC_WR,
	input wire logic [15:0] WR_DATA,
	// Status commands
	input wire logic STAT_PRESET,
	input wire logic CLEAR_STATUS,
	input wire logic OPC_CMD,
	input wire logic SERIAL_POLL,
	// Queries
	input wire logic QUERY,
	input wire logic [2:0] QUERY_SEL,
	output logic [15:0] QUERY_DATA,
	output logic QUERY_VALID,
	// Error queue
	input wire logic ERR_PUSH,
	input wire logic [ERR_W-1:0] ERR_TEXT,
	input wire logic ERR_POP,
	output logic [ERR_W-1:0] ERR_DATA,
	output logic ERR_VALID,
	output logic ERR_FULL,
	// Status byte and service request
	output logic [SRR_STB_W-1:0] STATUS_BYTE,
	output logic SRQ
);
	// ****************************************************************
	// State
	// ****************************************************************
	logic [QUES_W-1:0] ques_en_reg;
	logic [QUES_W-1:0] ques_ev_reg;
	logic [SRR_STD_W-1:0] std_en_reg;
	logic [SRR_STD_W-1:0] std_ev_reg;
	logic [SRR_STB_W-1:0] stb_en_reg;
	logic [SRR_STB_W-1:0] stb_ev_reg;
	logic psc_reg;
	logic rqs_reg;
	logic [15:0] qdata_reg;
	logic qvalid_reg;
	logic [SRR_STB_W-1:0] stb_reg;
	logic srq_reg;
	logic [ERR_W-1:0] err_reg;
	logic err_valid_reg;
	logic err_full_reg;
	logic [ERR_W-1:0] errq_head;
	logic errq_ne;
	logic errq_full;
	logic [15:0] query_mux;
	srr_query_e qsel;

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign qsel = srr_query_e'(QUERY_SEL);
	wire rd_ques_ev = QUERY && (qsel == SRR_Q_QUES_EV);
	wire rd_std_ev = QUERY && (qsel == SRR_Q_STD_EV);
	// The standard event and service request masks survive a power cycle only while the power-on clear setting is 0.
	wire pwr_clr = POWER_ON && psc_reg;
	wire ques_sum = |(ques_ev_reg & ques_en_reg);
	wire std_sum = |(std_ev_reg & std_en_reg);
	// Summary positions are owned by the bank; a raw condition there would fake a summary.
	wire [SRR_STB_W-1:0] stb_own = ~((8'h01 << SRR_EAV_BIT) | (8'h01 << SRR_QSUM_BIT) | (8'h01 << SRR_ESUM_BIT));
	wire [SRR_STB_W-1:0] stb_raw = ((stb_ev_reg & stb_own) | ({{(SRR_STB_W-1){1'b0}}, errq_ne} << SRR_EAV_BIT)
		| ({{(SRR_STB_W-1){1'b0}}, ques_sum} << SRR_QSUM_BIT)
		| ({{(SRR_STB_W-1){1'b0}}, std_sum} << SRR_ESUM_BIT))
		& ~(8'h01 << SRR_RQS_BIT);
	wire svc = |(stb_raw & stb_en_reg & ~(8'h01 << SRR_RQS_BIT));
	wire [SRR_STB_W-1:0] stb_full = stb_raw | ({{(SRR_STB_W-1){1'b0}}, rqs_reg} << SRR_RQS_BIT);
	wire [SRR_STD_W-1:0] std_set = STD_COND | (OPC_CMD ? (8'h01 << SRR_OPC_BIT) : 8'h00);

	// Event set wins over clear so a condition landing on a read is kept.
	wire [QUES_W-1:0] ques_ev_next = ((CLEAR_STATUS || rd_ques_ev) ? '0 : ques_ev_reg) | QUES_COND;
	wire [SRR_STD_W-1:0] std_ev_next = ((CLEAR_STATUS || rd_std_ev) ? '0 : std_ev_reg) | std_set;
	wire [SRR_STB_W-1:0] stb_ev_next = (CLEAR_STATUS ? SRR_STB_RST : stb_ev_reg) | STB_COND;
	// Request service is set whenever an enabled status bit is up and falls on serial poll or clear status.
	wire rqs_next = svc ? 1'b1 : ((SERIAL_POLL || CLEAR_STATUS) ? 1'b0 : rqs_reg);
	// The pin copy takes the request bit of the same edge as SRQ, so the two never disagree.
	wire [SRR_STB_W-1:0] stb_out = stb_raw | ({{(SRR_STB_W-1){1'b0}}, rqs_next} << SRR_RQS_BIT);

	always_comb begin
		unique case (qsel)
			SRR_Q_QUES_EN: query_mux = 16'(ques_en_reg);
			SRR_Q_QUES_EV: query_mux = 16'(ques_ev_reg);
			SRR_Q_STD_EN: query_mux = 16'(std_en_reg);
			SRR_Q_STD_EV: query_mux = 16'(std_ev_reg);
			SRR_Q_STB_EN: query_mux = 16'(stb_en_reg);
			SRR_Q_STB: query_mux = 16'(stb_full);
			SRR_Q_PSC: query_mux = 16'(psc_reg);
			SRR_Q_OPC: query_mux = 16'h0001;
		endcase
	end

	// ****************************************************************
	// Masks and setting
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ques_en_reg <= '0;
			std_en_reg <= SRR_STD_RST;
			stb_en_reg <= SRR_STB_RST;
			psc_reg <= SRR_PSC_RST;
		end else begin
			if (STAT_PRESET) begin
				ques_en_reg <= '0;
			end else if (QUES_EN_WR) begin
				ques_en_reg <= WR_DATA[QUES_W-1:0];
			end
			if (pwr_clr) begin
				std_en_reg <= SRR_STD_RST;
				stb_en_reg <= SRR_STB_RST;
			end else begin
				if (STD_EN_WR) begin
					std_en_reg <= WR_DATA[SRR_STD_W-1:0];
				end
				if (STB_EN_WR) begin
					stb_en_reg <= WR_DATA[SRR_STB_W-1:0];
				end
			end
			if (PSC_WR) begin
				psc_reg <= WR_DATA[0];
			end
		end
	end

	// ****************************************************************
	// Events and outputs
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ques_ev_reg <= '0;
			std_ev_reg <= SRR_STD_RST;
			stb_ev_reg <= SRR_STB_RST;
			rqs_reg <= 1'b0;
			qdata_reg <= 16'h0000;
			qvalid_reg <= 1'b0;
			stb_reg <= SRR_STB_RST;
			srq_reg <= 1'b0;
			err_reg <= '0;
			err_valid_reg <= 1'b0;
			err_full_reg <= 1'b0;
		end else begin
			ques_ev_reg <= ques_ev_next;
			std_ev_reg <= std_ev_next;
			stb_ev_reg <= stb_ev_next;
			rqs_reg <= rqs_next;
			qvalid_reg <= QUERY;
			if (QUERY) begin
				qdata_reg <= query_mux;
			end
			stb_reg <= stb_out;
			srq_reg <= rqs_next;
			// An empty queue shows zero rather than stale or never written storage.
			err_reg <= errq_ne ? errq_head : '0;
			err_valid_reg <= errq_ne;
			err_full_reg <= errq_full;
		end
	end

	assign QUERY_DATA = qdata_reg;
	assign QUERY_VALID = qvalid_reg;
	assign STATUS_BYTE = stb_reg;
	assign SRQ = srq_reg;
	assign ERR_VALID = err_valid_reg;
	assign ERR_FULL = err_full_reg;

	// ****************************************************************
	// Error queue
	// ****************************************************************
	// The queue sees only the hard reset; a configuration reset leaves it alone.
	srr_errq #(.DEPTH(ERRQ_DEPTH), .WIDTH(ERR_W)) u_errq (
		.clk(SYS_CLK),
		.rst(RST),
		.push(ERR_PUSH),
		.push_data(ERR_TEXT),
		.pop(ERR_POP),
		.head_data(errq_head),
		.not_empty(errq_ne),
		.full(errq_full)
	);
	assign ERR_DATA = err_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_QUES_PRESET: assert property (@(posedge SYS_CLK) disable iff (RST)
		STAT_PRESET |=> ques_en_reg == '0) else $error("Preset left questionable mask set.");
	AST_CLS_CLEARS: assert property (@(posedge SYS_CLK) disable iff (RST)
		CLEAR_STATUS && QUES_COND == '0 && STD_COND == 8'h00 && !OPC_CMD |=> ques_ev_reg == '0 && std_ev_reg == 8'h00)
		else $error("Clear status left events set.");
	AST_OPC_SETS: assert property (@(posedge SYS_CLK) disable iff (RST)
		OPC_CMD |=> std_ev_reg[SRR_OPC_BIT]) else $error("Operation complete bit not set.");
	AST_OPC_QUERY: assert property (@(posedge SYS_CLK) disable iff (RST)
		QUERY && qsel == SRR_Q_OPC |=> QUERY_VALID && QUERY_DATA == 16'h0001)
		else $error("Operation complete query did not answer 1.");
	AST_PSC_CLEAR: assert property (@(posedge SYS_CLK) disable iff (RST)
		POWER_ON && psc_reg |=> std_en_reg == 8'h00 && stb_en_reg == 8'h00)
		else $error("Power-on clear left masks set.");
	AST_PSC_KEEP: assert property (@(posedge SYS_CLK) disable iff (RST)
		POWER_ON && !psc_reg && !STD_EN_WR |=> std_en_reg == $past(std_en_reg))
		else $error("Mask lost across power-up with clear off.");
	AST_EV_LATCH: assert property (@(posedge SYS_CLK) disable iff (RST)
		std_ev_reg[SRR_STD_W-1] && !CLEAR_STATUS && !rd_std_ev |=> std_ev_reg[SRR_STD_W-1])
		else $error("Standard event bit dropped without clear.");
	AST_STB_SUM: assert property (@(posedge SYS_CLK) disable iff (RST)
		1'b1 |=> STATUS_BYTE[SRR_ESUM_BIT] == $past(std_sum) && STATUS_BYTE[SRR_QSUM_BIT] == $past(ques_sum))
		else $error("Status byte summary mismatch.");
	AST_RQS_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
		rqs_reg && !SERIAL_POLL && !CLEAR_STATUS |=> rqs_reg)
		else $error("Request service cleared without serial poll.");

	// ****************************************************************
	// Checks on writes, queries and service requests
	// ****************************************************************
	AST_QEN_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
		QUES_EN_WR && !STAT_PRESET |=> ques_en_reg == QUES_W'($past(WR_DATA)))
		else $error("Questionable mask write lost.");
	AST_SEN_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
		STD_EN_WR && !pwr_clr |=> std_en_reg == SRR_STD_W'($past(WR_DATA)))
		else $error("Standard event mask write lost.");
	AST_REN_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
		STB_EN_WR && !pwr_clr |=> stb_en_reg == SRR_STB_W'($past(WR_DATA)))
		else $error("Service request mask write lost.");
	AST_PSC_WRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
		PSC_WR |=> psc_reg == 1'($past(WR_DATA)))
		else $error("Power-on clear setting write lost.");
	AST_PSC_RETAIN: assert property (@(posedge SYS_CLK) disable iff (RST)
		POWER_ON && !PSC_WR |=> psc_reg == $past(psc_reg))
		else $error("Power-on clear setting lost across power-up.");
	AST_QEV_READ: assert property (@(posedge SYS_CLK) disable iff (RST)
		rd_ques_ev && QUES_COND == '0 |=> ques_ev_reg == '0)
		else $error("Questionable events kept after read.");
	AST_SEV_READ: assert property (@(posedge SYS_CLK) disable iff (RST)
		rd_std_ev && STD_COND == 8'h00 && !OPC_CMD |=> std_ev_reg == 8'h00)
		else $error("Standard events kept after read.");
	AST_QEV_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
		QUES_COND != '0 |=> (ques_ev_reg & $past(QUES_COND)) == $past(QUES_COND))
		else $error("Questionable condition not latched.");
	AST_SEV_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
		STD_COND != 8'h00 |=> (std_ev_reg & $past(STD_COND)) == $past(STD_COND))
		else $error("Standard condition not latched.");
	AST_QVALID: assert property (@(posedge SYS_CLK) disable iff (RST)
		1'b1 |=> QUERY_VALID == $past(QUERY))
		else $error("Query valid flag out of step with query.");
	AST_QEN_ANSWER: assert property (@(posedge SYS_CLK) disable iff (RST)
		QUERY && qsel == SRR_Q_QUES_EN |=> QUERY_DATA == 16'($past(ques_en_reg)))
		else $error("Questionable mask query answered wrong value.");
	AST_STB_ANSWER: assert property (@(posedge SYS_CLK) disable iff (RST)
		QUERY && qsel == SRR_Q_STB |=> QUERY_DATA[SRR_RQS_BIT] == $past(rqs_reg))
		else $error("Status byte query lost the request bit.");
	AST_SRQ_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
		svc |=> SRQ && STATUS_BYTE[SRR_RQS_BIT])
		else $error("Enabled status bit did not request service.");
	AST_SRQ_POLL: assert property (@(posedge SYS_CLK) disable iff (RST)
		SERIAL_POLL && !svc |=> !SRQ && !STATUS_BYTE[SRR_RQS_BIT])
		else $error("Serial poll did not clear request service.");
	AST_CLS_STATUS: assert property (@(posedge SYS_CLK) disable iff (RST)
		CLEAR_STATUS && STB_COND == 8'h00 && !svc |=> stb_ev_reg == 8'h00 && !rqs_reg)
		else $error("Clear status left status bits set.");
	AST_CFG_KEEPQ: assert property (@(posedge SYS_CLK) disable iff (RST)
		CFG_RESET && !ERR_PUSH && !ERR_POP |=> errq_ne == $past(errq_ne))
		else $error("Configuration reset disturbed the error queue.");
	AST_EAV_SUM: assert property (@(posedge SYS_CLK) disable iff (RST)
		1'b1 |=> STATUS_BYTE[SRR_EAV_BIT] == $past(errq_ne))
		else $error("Error available bit out of step with queue.");
endmodule : srr_top

// ==== tb/srr_ctl.sv ====
// Remote controller model that issues status commands and queries.
// Assumes the bank samples every strobe on the rising clock edge.
`timescale 1ns/10ps
module srr_ctl
	import srr_pkg::*;
(
	// Clock
	input wire logic clk,
	// Answers from the bank
	input wire logic [15:0] qdata,
	input wire logic qvalid,
	// Commands to the bank
	output logic [15:0] wr_data,
	output logic [15:0] strb,
	output logic [2:0] sel,
	output logic [639:0] err_text
);
	initial begin
		wr_data = 16'h0000;
		strb = 16'h0000;
		sel = 3'h0;
		err_text = '0;
	end
	// Released data is inverted so a stale value cannot pass for a held one.
	task automatic cmd(input int b, input logic [15:0] d);
		@(posedge clk) #1;
		strb[b] = 1'b1;
		wr_data = d;
		@(posedge clk) #1;
		strb[b] = 1'b0;
		wr_data = ~d;
	endtask : cmd
	// The answer is registered, so it is taken just after the edge that raises the valid flag.
	task automatic query(input logic [2:0] s, output logic [15:0] q, output logic v);
		@(posedge clk) #1;
		strb[8] = 1'b1;
		sel = s;
		@(posedge clk) #1;
		strb[8] = 1'b0;
		sel = ~s;
		q = qdata;
		v = qvalid;
	endtask : query
	task automatic push(input logic [639:0] t);
		err_text = t;
		cmd(9, 16'h0000);
		err_text = ~t;
	endtask : push
endmodule : srr_ctl

// ==== tb/tb.sv ====
// Self-checking bench for the status reporting bank.
// Assumes the controller model in srr_ctl drives all command strobes.
`timescale 1ns/10ps
module tb
	import srr_pkg::*;
;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic [15:0] ques_cond = 16'h0000;
	logic [7:0] std_cond = 8'h00;
	logic [7:0] stb_cond = 8'h00;
	logic [15:0] wr_data, strb, qdata, q;
	logic [2:0] sel;
	logic [639:0] err_text, err_data;
	logic qvalid, err_valid, err_full, srq, v;
	logic [7:0] status_byte;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	srr_ctl u (.clk(SYS_CLK), .qdata(qdata), .qvalid(qvalid), .wr_data(wr_data), .strb(strb), .sel(sel),
		.err_text(err_text));
	srr_top dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .POWER_ON(strb[11]), .CFG_RESET(strb[12]),
		.QUES_COND(ques_cond), .STD_COND(std_cond), .STB_COND(stb_cond), .QUES_EN_WR(strb[0]),
		.STD_EN_WR(strb[1]), .STB_EN_WR(strb[2]), .PSC_WR(strb[3]), .WR_DATA(wr_data),
		.STAT_PRESET(strb[4]), .CLEAR_STATUS(strb[5]), .OPC_CMD(strb[6]), .SERIAL_POLL(strb[7]),
		.QUERY(strb[8]), .QUERY_SEL(sel), .QUERY_DATA(qdata), .QUERY_VALID(qvalid),
		.ERR_PUSH(strb[9]), .ERR_TEXT(err_text), .ERR_POP(strb[10]), .ERR_DATA(err_data),
		.ERR_VALID(err_valid), .ERR_FULL(err_full), .STATUS_BYTE(status_byte), .SRQ(srq));
	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input logic [639:0] seen, input logic [639:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		$display("Counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic qchk(input logic [2:0] s, input logic [15:0] exp);
		u.query(s, q, v);
		check(q, exp);
		check(v, 1'b1);
	endtask : qchk
	task automatic wait_n(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : wait_n
	task automatic pulse(input logic [15:0] qc, input logic [7:0] sc, input logic [7:0] bc);
		@(posedge SYS_CLK) #1;
		ques_cond = qc;
		std_cond = sc;
		stb_cond = bc;
		@(posedge SYS_CLK) #1;
		ques_cond = 16'h0000;
		std_cond = 8'h00;
		stb_cond = 8'h00;
	endtask : pulse
	// The whole run needs well under a thousand cycles.
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			give_verdict();
		end
	end
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (2) @(posedge SYS_CLK);
		#1 RST = 1'b0;
		qchk(SRR_Q_PSC, 16'h0001);
		qchk(SRR_Q_OPC, 16'h0001);
		u.cmd(0, 16'hA5C3);
		u.cmd(1, 16'h0001);
		u.cmd(2, 16'h0020);
		qchk(SRR_Q_QUES_EN, 16'hA5C3);
		qchk(SRR_Q_STD_EN, 16'h0001);
		qchk(SRR_Q_STB_EN, 16'h0020);
		$display("Test masks done");
		pulse(16'h0104, 8'h00, 8'h00);
		wait_n(2);
		check(status_byte[3], 1'b1);
		qchk(SRR_Q_QUES_EV, 16'h0104);
		qchk(SRR_Q_QUES_EV, 16'h0000);
		u.cmd(4, 16'h0000);
		qchk(SRR_Q_QUES_EN, 16'h0000);
		wait_n(2);
		check(status_byte[3], 1'b0);
		$display("Test questionable done");
		u.cmd(6, 16'h0000);
		wait_n(2);
		check(status_byte[5], 1'b1);
		check(srq, 1'b1);
		qchk(SRR_Q_STB, 16'h0060);
		check(srq, 1'b1);
		qchk(SRR_Q_STD_EV, 16'h0001);
		u.cmd(7, 16'h0000);
		wait_n(1);
		check(srq, 1'b0);
		check(status_byte[6], 1'b0);
		qchk(SRR_Q_STB, 16'h0000);
		pulse(16'h8000, 8'h80, 8'h01);
		wait_n(2);
		check(status_byte[5], 1'b0);
		check(status_byte[0], 1'b1);
		check(srq, 1'b0);
		u.cmd(5, 16'h0000);
		wait_n(2);
		check(status_byte, 8'h00);
		qchk(SRR_Q_STD_EV, 16'h0000);
		qchk(SRR_Q_QUES_EV, 16'h0000);
		$display("Test standard events done");
		u.cmd(2, 16'h0020);
		u.cmd(3, 16'h0000);
		qchk(SRR_Q_PSC, 16'h0000);
		u.cmd(11, 16'h0000);
		qchk(SRR_Q_STD_EN, 16'h0001);
		qchk(SRR_Q_STB_EN, 16'h0020);
		u.cmd(3, 16'h0001);
		u.cmd(11, 16'h0000);
		qchk(SRR_Q_STD_EN, 16'h0000);
		qchk(SRR_Q_STB_EN, 16'h0000);
		qchk(SRR_Q_PSC, 16'h0001);
		$display("Test power-on clear done");
		// One entry past the depth is pushed and must be dropped.
		for (int i = 0; i < 21; i++)
			u.push({80{8'(i + 65)}});
		wait_n(2);
		check(err_full, 1'b1);
		check(status_byte[2], 1'b1);
		u.cmd(12, 16'h0000);
		for (int i = 0; i < 20; i++) begin
			check(err_data, {80{8'(i + 65)}});
			u.cmd(10, 16'h0000);
			wait_n(1);
		end
		check(err_valid, 1'b0);
		$display("Test error queue done");
		give_verdict();
	end
endmodule : tb
